// >>> dpwm_pkg.sv
/*
 * Constants shared by the dual channel pulse width modulator: register indices,
 * address window bases, field positions, reset values and prescaler sizing.
 * Assumes a 32-bit APB master whose byte address is four times the register
 * index, with the index taken relative to one of two window bases.
 */

package dpwm_pkg;

	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W        = 12;
	localparam logic [9:0]  BASE_BLOCKING = 10'h200; // Word index base, blocking access
	localparam logic [9:0]  BASE_NONBLOCK = 10'h300; // Word index base, non-blocking access

	localparam logic [7:0] IDX_CONTROL  = 8'h60;
	localparam logic [7:0] IDX_PRESCALE = 8'h61;
	localparam logic [7:0] IDX_SCALE_A  = 8'h62;
	localparam logic [7:0] IDX_SCALE_B  = 8'h63;
	localparam logic [7:0] IDX_CNT0     = 8'h64;
	localparam logic [7:0] IDX_CNT1     = 8'h65;
	localparam logic [7:0] IDX_PER0     = 8'h66;
	localparam logic [7:0] IDX_PER1     = 8'h67;
	localparam logic [7:0] IDX_DTY0     = 8'h68;
	localparam logic [7:0] IDX_DTY1     = 8'h69;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned CTL_ENABLE_LSB   = 0; // channel_output_enable[1:0]
	localparam int unsigned CTL_POLARITY_LSB = 2; // output_start_polarity[1:0]
	localparam int unsigned CTL_CH0_CLK_SEL  = 4; // ch0_clock_select
	localparam int unsigned CTL_CH1_CLK_SEL  = 5; // ch1_clock_select
	localparam int unsigned CTL_CENTER_LSB   = 6; // center_align_select[1:0]
	localparam int unsigned PRE_A_LSB        = 0; // clock_a_prescale_field
	localparam int unsigned PRE_B_LSB        = 4; // clock_b_prescale_field
	localparam logic [7:0]  PRE_WRITE_MASK   = 8'h77;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CONTROL  = 8'h00;
	localparam logic [7:0] RST_PRESCALE = 8'h00;
	localparam logic [7:0] RST_SCALE    = 8'h00;
	localparam logic [7:0] RST_COUNT    = 8'h00;
	localparam logic [7:0] RST_PERIOD   = 8'h00;
	localparam logic [7:0] RST_DUTY     = 8'h00;

	// Prescaler divides by up to 2^7
	localparam int unsigned PRESC_W     = 7;
	localparam logic [6:0]  RST_PRESC   = 7'h00;

endpackage : dpwm_pkg

// >>> dpwm_top.sv
/*
 * Dual channel pulse width modulator with APB register access.
 * Holds the register file, prescaler, scaled clocks, the two channel
 * counters with buffered period and duty, and the driver outputs.
 * Assumes op_mode_normal comes from mode control logic on pclk.
 */
// The APB slave port was decided locally.
`timescale 1ns/1ps

module dpwm_top import dpwm_pkg::*; (
	input  wire logic              pclk,                // Bus clock, 250 MHz
	input  wire logic              presetn,             // Async reset, active low
	input  wire logic              psel,                // APB select
	input  wire logic              penable,             // APB access phase
	input  wire logic              pwrite,              // APB direction, 1 = write
	input  wire logic [ADDR_W-1:0] paddr,               // APB byte address
	input  wire logic [31:0]       pwdata,              // APB write data
	output logic [31:0]            prdata,              // APB read data
	output logic                   pready,              // APB ready
	output logic                   pslverr,             // APB error on unmapped address
	input  wire logic              op_mode_normal,      // Device is in Normal mode
	output logic                   modulator_out0,      // Channel 0 waveform
	output logic                   modulator_out1,      // Channel 1 waveform
	output logic                   high_side_driver_1,  // High side stage duty control
	output logic                   low_side_driver_1,   // Low side stage duty control
	output logic                   general_output_pin2  // General purpose pin drive
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Low-bit mask of a power-of-two divider: field n divides by 2^n
	function automatic logic [PRESC_W-1:0] div_mask(input logic [2:0] sel);
		div_mask = PRESC_W'((8'h01 << sel) - 8'h01);
	endfunction

	// Translate a word index to a register index inside one window
	function automatic logic win_hit(input logic [9:0] word, input logic [9:0] base,
		output logic [7:0] idx);
		logic [9:0] rel;
		rel = word - base;
		idx = rel[7:0];
		win_hit = (rel >= {2'b00, IDX_CONTROL}) && (rel <= {2'b00, IDX_DTY1});
	endfunction

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0]         ctl_r,      ctl_nxt;
	logic [7:0]         presel_r,   presel_nxt;
	logic [7:0]         scla_r,     scla_nxt;
	logic [7:0]         sclb_r,     sclb_nxt;
	logic [7:0]         per_buf_r  [2];
	logic [7:0]         per_buf_nxt[2];
	logic [7:0]         dty_buf_r  [2];
	logic [7:0]         dty_buf_nxt[2];
	logic [7:0]         per_act_r  [2];
	logic [7:0]         per_act_nxt[2];
	logic [7:0]         dty_act_r  [2];
	logic [7:0]         dty_act_nxt[2];
	logic [7:0]         cnt_r      [2];
	logic [7:0]         cnt_nxt    [2];
	logic [1:0]         down_r,     down_nxt;
	logic [1:0]         run_r,      run_nxt;
	logic [1:0]         wave_r,     wave_nxt;
	logic [PRESC_W-1:0] presc_r,    presc_nxt;
	logic [7:0]         sa_cnt_r,   sa_cnt_nxt;
	logic [7:0]         sb_cnt_r,   sb_cnt_nxt;
	logic [31:0]        prdata_r,   prdata_nxt;
	logic               pready_r,   pready_nxt;
	logic               pslverr_r,  pslverr_nxt;
	logic               drv_hs_r,   drv_hs_nxt;
	logic               drv_ls_r,   drv_ls_nxt;
	logic               drv_gp_r,   drv_gp_nxt;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	logic       hit_blk;
	logic       hit_nblk;
	logic       addr_hit;
	logic [7:0] idx_blk;
	logic [7:0] idx_nblk;
	logic [7:0] reg_idx;
	logic       bus_write;

	always_comb begin
		hit_blk  = win_hit(paddr[ADDR_W-1:2], BASE_BLOCKING, idx_blk);
		hit_nblk = win_hit(paddr[ADDR_W-1:2], BASE_NONBLOCK, idx_nblk);
		addr_hit = hit_blk | hit_nblk;
		reg_idx  = hit_blk ? idx_blk : idx_nblk;
		// Writes land only at the completing edge of the access phase
		bus_write = psel & penable & pready_r & pwrite & addr_hit;
	end

	// ----------------------------------------------------------------
	// Prescaler and channel clocks
	// ----------------------------------------------------------------
	logic       mode_ok;
	logic       any_en;
	logic       tick_a;
	logic       tick_b;
	logic       tick_sa;
	logic       tick_sb;
	logic [1:0] ch_tick;
	logic [1:0] ch_en;

	always_comb begin
		mode_ok = op_mode_normal;
		ch_en   = ctl_r[CTL_ENABLE_LSB +: 2] & {2{mode_ok}};
		any_en  = |ch_en;
		// Counter idles at zero while nothing is enabled to save power
		presc_nxt = any_en ? presc_r + PRESC_W'(1) : RST_PRESC;
		tick_a = any_en && ((presc_r & div_mask(presel_r[PRE_A_LSB +: 3]))
			== div_mask(presel_r[PRE_A_LSB +: 3]));
		tick_b = any_en && ((presc_r & div_mask(presel_r[PRE_B_LSB +: 3]))
			== div_mask(presel_r[PRE_B_LSB +: 3]));
		// Scale value 0 wraps to a divide by 256
		tick_sa = tick_a && (sa_cnt_r == scla_r - 8'h01);
		tick_sb = tick_b && (sb_cnt_r == sclb_r - 8'h01);
		sa_cnt_nxt = sa_cnt_r;
		sb_cnt_nxt = sb_cnt_r;
		if (!any_en) begin
			sa_cnt_nxt = RST_COUNT;
			sb_cnt_nxt = RST_COUNT;
		end else begin
			if (tick_a) begin
				sa_cnt_nxt = tick_sa ? RST_COUNT : sa_cnt_r + 8'h01;
			end
			if (tick_b) begin
				sb_cnt_nxt = tick_sb ? RST_COUNT : sb_cnt_r + 8'h01;
			end
		end
		// A scale write restarts the divider so the new ratio starts clean
		if (bus_write && reg_idx == IDX_SCALE_A) begin
			sa_cnt_nxt = RST_COUNT;
		end
		if (bus_write && reg_idx == IDX_SCALE_B) begin
			sb_cnt_nxt = RST_COUNT;
		end
		// Selection may change at any time; one pulse can be cut or stretched
		ch_tick[0] = ctl_r[CTL_CH0_CLK_SEL] ? tick_sa : tick_a;
		ch_tick[1] = ctl_r[CTL_CH1_CLK_SEL] ? tick_sb : tick_b;
	end

	// ----------------------------------------------------------------
	// Register file writes
	// ----------------------------------------------------------------
	always_comb begin
		ctl_nxt    = ctl_r;
		presel_nxt = presel_r;
		scla_nxt   = scla_r;
		sclb_nxt   = sclb_r;
		for (int i = 0; i < 2; i++) begin
			per_buf_nxt[i] = per_buf_r[i];
			dty_buf_nxt[i] = dty_buf_r[i];
		end
		if (bus_write) begin
			unique case (reg_idx)
				IDX_CONTROL:  ctl_nxt    = pwdata[7:0];
				IDX_PRESCALE: presel_nxt = pwdata[7:0] & PRE_WRITE_MASK;
				IDX_SCALE_A:  scla_nxt   = pwdata[7:0];
				IDX_SCALE_B:  sclb_nxt   = pwdata[7:0];
				IDX_PER0:     per_buf_nxt[0] = pwdata[7:0];
				IDX_PER1:     per_buf_nxt[1] = pwdata[7:0];
				IDX_DTY0:     dty_buf_nxt[0] = pwdata[7:0];
				IDX_DTY1:     dty_buf_nxt[1] = pwdata[7:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Channel counters and waveforms
	// ----------------------------------------------------------------
	logic [1:0] cnt_wr;
	logic [1:0] active;

	always_comb begin
		cnt_wr[0] = bus_write && (reg_idx == IDX_CNT0);
		cnt_wr[1] = bus_write && (reg_idx == IDX_CNT1);
		for (int i = 0; i < 2; i++) begin
			cnt_nxt[i]     = cnt_r[i];
			down_nxt[i]    = down_r[i];
			run_nxt[i]     = run_r[i];
			per_act_nxt[i] = per_act_r[i];
			dty_act_nxt[i] = dty_act_r[i];
			if (cnt_wr[i] || !ch_en[i]) begin
				// Idle or forced restart: take the buffered values now
				cnt_nxt[i]     = RST_COUNT;
				down_nxt[i]    = 1'b0;
				per_act_nxt[i] = per_buf_r[i];
				dty_act_nxt[i] = dty_buf_r[i];
				if (!ch_en[i]) begin
					run_nxt[i] = 1'b0;
				end
			end else if (ch_tick[i]) begin
				// Enable is synchronised to the first tick of the chosen clock
				run_nxt[i] = 1'b1;
				if (!ctl_r[CTL_CENTER_LSB + i]) begin
					if (cnt_r[i] + 8'h01 >= per_act_r[i] || per_act_r[i] == 8'h00) begin
						cnt_nxt[i]     = RST_COUNT;
						per_act_nxt[i] = per_buf_r[i];
						dty_act_nxt[i] = dty_buf_r[i];
					end else begin
						cnt_nxt[i] = cnt_r[i] + 8'h01;
					end
				end else if (!down_r[i]) begin
					if (cnt_r[i] >= per_act_r[i]) begin
						down_nxt[i] = per_act_r[i] != 8'h00;
						cnt_nxt[i]  = (per_act_r[i] == 8'h00) ? RST_COUNT : cnt_r[i] - 8'h01;
						if (per_act_r[i] == 8'h00) begin
							per_act_nxt[i] = per_buf_r[i];
							dty_act_nxt[i] = dty_buf_r[i];
						end
					end else begin
						cnt_nxt[i] = cnt_r[i] + 8'h01;
					end
				end else begin
					if (cnt_r[i] <= 8'h01) begin
						// Period ends at zero in center mode
						cnt_nxt[i]     = RST_COUNT;
						down_nxt[i]    = 1'b0;
						per_act_nxt[i] = per_buf_r[i];
						dty_act_nxt[i] = dty_buf_r[i];
					end else begin
						cnt_nxt[i] = cnt_r[i] - 8'h01;
					end
				end
			end
			// Nonzero duty at or above the period keeps the output fully active
			active[i] = (cnt_r[i] < dty_act_r[i]) || (dty_act_r[i] >= per_act_r[i]
				&& dty_act_r[i] != 8'h00);
			// Polarity is read live, so a change mid-pulse alters one pulse
			wave_nxt[i] = (ch_en[i] && run_r[i]) ?
				(active[i] ? ctl_r[CTL_POLARITY_LSB + i] : !ctl_r[CTL_POLARITY_LSB + i])
				: 1'b0;
		end
		drv_hs_nxt = wave_nxt[1];
		drv_ls_nxt = wave_nxt[0];
		drv_gp_nxt = wave_nxt[0];
	end

	// ----------------------------------------------------------------
	// APB response
	// ----------------------------------------------------------------
	logic [7:0] rd_byte;

	always_comb begin
		unique case (reg_idx)
			IDX_CONTROL:  rd_byte = ctl_r;
			IDX_PRESCALE: rd_byte = presel_r & PRE_WRITE_MASK;
			IDX_SCALE_A:  rd_byte = scla_r;
			IDX_SCALE_B:  rd_byte = sclb_r;
			IDX_CNT0:     rd_byte = cnt_r[0];
			IDX_CNT1:     rd_byte = cnt_r[1];
			IDX_PER0:     rd_byte = per_buf_r[0];
			IDX_PER1:     rd_byte = per_buf_r[1];
			IDX_DTY0:     rd_byte = dty_buf_r[0];
			IDX_DTY1:     rd_byte = dty_buf_r[1];
			default:      rd_byte = 8'h00;
		endcase
		// Answer is prepared at the setup edge, so every access has no wait state
		pready_nxt  = psel && !penable && !pready_r;
		prdata_nxt  = prdata_r;
		pslverr_nxt = 1'b0;
		if (psel && !penable && !pready_r) begin
			prdata_nxt  = (addr_hit && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
			pslverr_nxt = !addr_hit;
		end
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_r     <= RST_CONTROL;
			presel_r  <= RST_PRESCALE;
			scla_r    <= RST_SCALE;
			sclb_r    <= RST_SCALE;
			for (int i = 0; i < 2; i++) begin
				per_buf_r[i] <= RST_PERIOD;
				dty_buf_r[i] <= RST_DUTY;
				per_act_r[i] <= RST_PERIOD;
				dty_act_r[i] <= RST_DUTY;
				cnt_r[i]     <= RST_COUNT;
			end
			down_r    <= 2'h0;
			run_r     <= 2'h0;
			wave_r    <= 2'h0;
			presc_r   <= RST_PRESC;
			sa_cnt_r  <= RST_COUNT;
			sb_cnt_r  <= RST_COUNT;
			prdata_r  <= 32'h00000000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			drv_hs_r  <= 1'b0;
			drv_ls_r  <= 1'b0;
			drv_gp_r  <= 1'b0;
		end else begin
			ctl_r     <= ctl_nxt;
			presel_r  <= presel_nxt;
			scla_r    <= scla_nxt;
			sclb_r    <= sclb_nxt;
			for (int i = 0; i < 2; i++) begin
				per_buf_r[i] <= per_buf_nxt[i];
				dty_buf_r[i] <= dty_buf_nxt[i];
				per_act_r[i] <= per_act_nxt[i];
				dty_act_r[i] <= dty_act_nxt[i];
				cnt_r[i]     <= cnt_nxt[i];
			end
			down_r    <= down_nxt;
			run_r     <= run_nxt;
			wave_r    <= wave_nxt;
			presc_r   <= presc_nxt;
			sa_cnt_r  <= sa_cnt_nxt;
			sb_cnt_r  <= sb_cnt_nxt;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			drv_hs_r  <= drv_hs_nxt;
			drv_ls_r  <= drv_ls_nxt;
			drv_gp_r  <= drv_gp_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata              = prdata_r;
	assign pready              = pready_r;
	assign pslverr             = pslverr_r;
	assign modulator_out0      = wave_r[0];
	assign modulator_out1      = wave_r[1];
	assign high_side_driver_1  = drv_hs_r;
	assign low_side_driver_1   = drv_ls_r;
	assign general_output_pin2 = drv_gp_r;

endmodule // dpwm_top

// >>> dpwm_props.sv
/*
 * Port checks for dpwm_top: APB answer timing, decode, reserved bits,
 * driver copies and output gating by mode and channel enable.
 * Assumes it is bound into dpwm_top and sees only its ports.
 */
`timescale 1ns/1ps

module dpwm_props import dpwm_pkg::*; (
	input wire logic              pclk,                // Bus clock
	input wire logic              presetn,             // Async reset, active low
	input wire logic              psel,                // APB select
	input wire logic              penable,             // APB access phase
	input wire logic              pwrite,              // APB direction
	input wire logic [ADDR_W-1:0] paddr,               // APB byte address
	input wire logic [31:0]       pwdata,              // APB write data
	input wire logic [31:0]       prdata,              // APB read data
	input wire logic              pready,              // APB ready
	input wire logic              pslverr,             // APB error
	input wire logic              op_mode_normal,      // Normal mode
	input wire logic              modulator_out0,      // Channel 0 waveform
	input wire logic              modulator_out1,      // Channel 1 waveform
	input wire logic              high_side_driver_1,  // High side drive
	input wire logic              low_side_driver_1,   // Low side drive
	input wire logic              general_output_pin2  // General pin drive
);
	// ----------------------------------------------------------------
	// Decode and enable shadow
	// ----------------------------------------------------------------
	logic [9:0] word;
	logic [9:0] rel;
	logic       hit;
	logic       ctl_wr;
	logic [1:0] en_r;
	logic [1:0] en_nxt;

	assign word = paddr[ADDR_W-1:2];
	assign rel = (word >= BASE_NONBLOCK) ? word - BASE_NONBLOCK : word - BASE_BLOCKING;
	assign hit = (word >= BASE_BLOCKING) && rel >= 10'(IDX_CONTROL) && rel <= 10'(IDX_DTY1);
	assign ctl_wr = psel && penable && pready && pwrite && hit && rel == 10'(IDX_CONTROL);

	// Shadow follows only completed writes, so a refused transfer cannot move it
	always_comb en_nxt = ctl_wr ? pwdata[1:0] : en_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			en_r <= 2'h0;
		else
			en_r <= en_nxt;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence setup_s; psel && !penable; endsequence
	sequence access_s; psel && penable && pready; endsequence
	sequence read_s; access_s ##0 !pwrite; endsequence

	zero_wait_a: assert property (setup_s |=> pready)
		else $error("pready missing after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	slverr_map_a: assert property (access_s |-> pslverr == !hit)
		else $error("pslverr does not match decode");
	upper_zero_a: assert property (read_s |-> prdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	unmap_zero_a: assert property (read_s ##0 !hit |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	rsv_bits_a: assert property (read_s ##0 (hit && rel == 10'(IDX_PRESCALE))
		|-> prdata[7] == 1'b0 && prdata[3] == 1'b0)
		else $error("reserved prescale bits not zero");
	mode_idle_a: assert property (!op_mode_normal [*2] |-> !modulator_out0 && !modulator_out1)
		else $error("waveform outside Normal mode");
	hs_copy_a: assert property (high_side_driver_1 == modulator_out1)
		else $error("high side differs from channel 1");
	ls_copy_a: assert property (low_side_driver_1 == modulator_out0
		&& general_output_pin2 == modulator_out0)
		else $error("low side or pin differs from channel 0");
	ch_off_a: assert property (en_r == 2'h0 [*2] |-> !modulator_out0 && !modulator_out1)
		else $error("output active while channels disabled");
endmodule // dpwm_props

bind dpwm_top dpwm_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .op_mode_normal(op_mode_normal),
	.modulator_out0(modulator_out0), .modulator_out1(modulator_out1),
	.high_side_driver_1(high_side_driver_1), .low_side_driver_1(low_side_driver_1),
	.general_output_pin2(general_output_pin2));

// >>> dpwm_drv_model.sv
/*
 * Driver stage model: counts active cycles and rising edges of the low side
 * (channel 0) and high side (channel 1) drives, and watches the pin copy.
 * Assumes clr is driven from pclk and pulsed before every reading.
 */
`timescale 1ns/1ps

module dpwm_drv_model (
	input  wire logic   pclk,   // Bus clock
	input  wire logic   clr,    // Restart counts
	input  wire logic   ls_in,  // Low side drive
	input  wire logic   hs_in,  // High side drive
	input  wire logic   gp_in,  // General pin drive
	output logic [15:0] high0,  // Active cycles, channel 0
	output logic [15:0] rise0,  // Rising edges, channel 0
	output logic [15:0] high1,  // Active cycles, channel 1
	output logic [15:0] rise1,  // Rising edges, channel 1
	output logic        gp_ok   // Pin tracked low side since clr
);
	logic ls_q;
	logic hs_q;

	always @(posedge pclk) begin
		ls_q <= ls_in;
		hs_q <= hs_in;
		if (clr) begin
			high0 <= 16'h0;
			rise0 <= 16'h0;
			high1 <= 16'h0;
			rise1 <= 16'h0;
			gp_ok <= 1'b1;
		end else begin
			high0 <= high0 + 16'(ls_in);
			rise0 <= rise0 + 16'(ls_in && !ls_q);
			high1 <= high1 + 16'(hs_in);
			rise1 <= rise1 + 16'(hs_in && !hs_q);
			if (gp_in !== ls_in)
				gp_ok <= 1'b0;
		end
	end
endmodule // dpwm_drv_model

// >>> dpwm_top_tb_top.sv
/*
 * Self-checking bench for dpwm_top: register access over APB, duty and
 * polarity, clock sources, alignment, mode and enable gating.
 * Assumes the driver model beside the design and the bound checker.
 */
`timescale 1ns/1ps

module dpwm_top_tb_top import dpwm_pkg::*;;
	logic pclk = 1'b0, presetn, psel, penable, pwrite, op_mode_normal, clr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic pready, pslverr, rerr, out0, out1, hs, ls, gp, gp_ok;
	logic [15:0] high0, rise0, high1, rise1;
	int bad_count = 0, comparisons = 0;
	int dl[5] = '{0, 1, 3, 4, 6};
	logic [7:0] pre[7] = '{8'h00, 8'h10, 8'h20, 8'h10, 8'h01, 8'h01, 8'h00};
	logic [7:0] ctl[7] = '{8'h0A, 8'h0A, 8'h0A, 8'h2A, 8'h15, 8'h05, 8'h45};
	int rr[7] = '{16, 8, 4, 4, 4, 8, 8};

	always #2 pclk = ~pclk;

	dpwm_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .op_mode_normal(op_mode_normal), .modulator_out0(out0),
		.modulator_out1(out1), .high_side_driver_1(hs), .low_side_driver_1(ls),
		.general_output_pin2(gp));
	dpwm_drv_model u_drv (.pclk(pclk), .clr(clr), .ls_in(ls), .hs_in(hs), .gp_in(gp),
		.high0(high0), .rise0(rise0), .high1(high1), .rise1(rise1), .gp_ok(gp_ok));

	// ----------------------------------------------------------------
	// Access and compare tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [9:0] base, input logic [7:0] idx,
		input logic [7:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {base + 10'(idx), 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, BASE_BLOCKING, idx, d);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, BASE_BLOCKING, idx, 8'h00);
		check(rdata, {24'h0, exp});
	endtask

	// Settles first so buffered values and the irregular first cycle are past
	task automatic meas(input logic ch, input int cyc, input int eh, input int er);
		repeat (80) @(posedge pclk);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		repeat (cyc) @(posedge pclk);
		@(negedge pclk);
		if (eh >= 0)
			check(32'(ch ? high1 : high0), 32'(eh));
		check(32'(ch ? rise1 : rise0), 32'(er));
		check(32'(gp_ok), 32'h1);
		check(32'({out1, out0}), 32'({hs, ls}));
		@(posedge pclk);
	endtask

	task automatic stop_test();
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		stop_test();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, clr} = 5'h0;
		paddr = '0;
		pwdata = 32'h0;
		op_mode_normal = 1'b1;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 10; i++)
			rd(IDX_CONTROL + 8'(i), 8'h00);
		wr(IDX_PRESCALE, 8'hFF);
		rd(IDX_PRESCALE, 8'h77);
		apb(1'b0, BASE_BLOCKING, 8'h70, 8'h00);
		check({rdata[31:1], rerr}, 32'h1);
		apb(1'b1, BASE_NONBLOCK, IDX_PER0, 8'h04);
		rd(IDX_PER0, 8'h04);
		wr(IDX_CNT0, 8'hFF);
		rd(IDX_CNT0, 8'h00);
		$display("test registers done");
		wr(IDX_PRESCALE, 8'h00);
		wr(IDX_CONTROL, 8'h05);
		foreach (dl[i]) begin
			wr(IDX_DTY0, 8'(dl[i]));
			meas(1'b0, 40, 10 * (dl[i] > 4 ? 4 : dl[i]),
				(dl[i] == 0 || dl[i] >= 4) ? 0 : 10);
		end
		wr(IDX_DTY0, 8'h01);
		wr(IDX_CONTROL, 8'h01);
		meas(1'b0, 40, 30, 10);
		// Counter write while running: cleared, then one tick before the read setup
		wr(IDX_CNT0, 8'hFF);
		rd(IDX_CNT0, 8'h01);
		$display("test duty done");
		wr(IDX_SCALE_A, 8'h02);
		wr(IDX_SCALE_B, 8'h02);
		wr(IDX_DTY0, 8'h02);
		wr(IDX_PER1, 8'h04);
		wr(IDX_DTY1, 8'h02);
		foreach (pre[i]) begin
			wr(IDX_PRESCALE, pre[i]);
			wr(IDX_CONTROL, ctl[i]);
			meas(!ctl[i][0], 64, ctl[i][6] ? -1 : 32, rr[i]);
		end
		$display("test clocks done");
		op_mode_normal <= 1'b0;
		meas(1'b0, 64, 0, 0);
		op_mode_normal <= 1'b1;
		wr(IDX_CONTROL, 8'h02);
		meas(1'b0, 64, 0, 0);
		meas(1'b1, 64, 32, 16);
		$display("test gating done");
		stop_test();
	end
endmodule // dpwm_top_tb_top
